// ==== pkg/lbc_pkg.sv ====
// Purpose: shared constants for the group blink and chase gating block
// Assumes: 10 MHz system clock, word-addressed register slave
// Notes:   register offsets are word indices; byte address is four times the index
package lbc_pkg;
   localparam int unsigned CLK_HZ          = 10_000_000;
   // blink step is one twenty-fourth of a second, split into 256 duty slices
   localparam int unsigned BLINK_STEP_DIV  = 24;
   localparam int unsigned DIM_FREQ_HZ     = 190;
   localparam int unsigned DUTY_STEPS      = 256;
   localparam int unsigned BLINK_SLICE_CYC = CLK_HZ / (BLINK_STEP_DIV * DUTY_STEPS);
   localparam int unsigned DIM_SLICE_CYC   = CLK_HZ / (DIM_FREQ_HZ * DUTY_STEPS);

   localparam int unsigned NUM_CH          = 24;
   localparam int unsigned NUM_STATE_REGS  = 6;

   // register indices
   localparam logic [5:0] IDX_SECOND_MODE  = 6'h01;
   localparam logic [5:0] IDX_GROUP_DUTY   = 6'h1A;
   localparam logic [5:0] IDX_GROUP_PERIOD = 6'h1B;
   localparam logic [5:0] IDX_CHASE_INDEX  = 6'h1C;
   localparam logic [5:0] IDX_STATE_FIRST  = 6'h1D;
   localparam logic [5:0] IDX_STATE_LAST   = 6'h22;
   localparam logic [5:0] IDX_STATUS       = 6'h27;

   // second mode register fields
   localparam int unsigned MODE_BLINK_BIT  = 5;
   localparam int unsigned MODE_OCH_BIT    = 3;
   localparam logic [7:0]  MODE_FIXED_ONES = 8'h05;

   // reset values
   localparam logic [7:0] RST_GROUP_DUTY   = 8'hFF;
   localparam logic [7:0] RST_GROUP_PERIOD = 8'h00;
   localparam logic [7:0] RST_CHASE_INDEX  = 8'h00;
   localparam logic [7:0] RST_STATE        = 8'h00;

   // chase index that ends chase operation
   localparam logic [7:0] CHASE_EXIT       = 8'hFF;

   // output state codes
   localparam logic [1:0] ST_OFF           = 2'h0;
   localparam logic [1:0] ST_ON            = 2'h1;
   localparam logic [1:0] ST_INDIV         = 2'h2;
   localparam logic [1:0] ST_GROUP         = 2'h3;
endpackage : lbc_pkg

// ==== rtl/lbc_tick_div.sv ====
// Purpose: free-running divider giving a one-cycle enable pulse
// Assumes: CYCLES of at least 2
// Notes:   pulse once every CYCLES clocks
`timescale 1ns/1ns
module lbc_tick_div #(
   parameter int unsigned CYCLES = 2
) (
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   output logic      o_tick
);
   localparam logic [15:0] LAST = 16'(CYCLES - 1);
   logic [15:0] count;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         count  <= 16'h0000;
         o_tick <= 1'b0;
      end else if (count == LAST) begin
         count  <= 16'h0000;
         o_tick <= 1'b1;
      end else begin
         count  <= count + 16'h0001;
         o_tick <= 1'b0;
      end
   end
endmodule : lbc_tick_div

// ==== rtl/lbc_chase_decode.sv ====
// Purpose: maps a chase index onto a 24-channel enable mask
// Assumes: bit n of the mask is channel n
// Notes:   purely combinational
`timescale 1ns/1ns
module lbc_chase_decode (
   input  wire logic [7:0]  i_index,
   output logic      [23:0] o_mask
);
   always_comb begin
      int i;
      int m;
      i = int'(i_index);
      m = 0;
      o_mask = 24'h000000;
      for (int n = 0; n < 24; n++) begin
         m = 23 - n;
         if (i == 0) o_mask[n] = 1'b1;
         else if (i == 2) o_mask[n] = (n % 2) == 1;
         else if (i == 3) o_mask[n] = (n % 2) == 0;
         else if (i == 4) o_mask[n] = (n % 3) == 2;
         else if (i == 5) o_mask[n] = (n % 3) == 1;
         else if (i == 6) o_mask[n] = (n % 3) == 0;
         else if (i >= 8'h07 && i <= 8'h1E) o_mask[n] = n == i - 8'h07;
         else if (i >= 8'h1F && i <= 8'h2A) o_mask[n] = n / 2 == i - 8'h1F;
         else if (i >= 8'h2B && i <= 8'h32) o_mask[n] = n / 3 == i - 8'h2B;
         else if (i >= 8'h33 && i <= 8'h38) o_mask[n] = n / 4 == i - 8'h33;
         else if (i >= 8'h39 && i <= 8'h3D) o_mask[n] = n / 5 == i - 8'h39;
         else if (i >= 8'h3E && i <= 8'h41) o_mask[n] = n / 6 == i - 8'h3E;
         else if (i >= 8'h42 && i <= 8'h4D) o_mask[n] = n == i - 8'h42 || m == i - 8'h42;
         else if (i >= 8'h4E && i <= 8'h52)
            o_mask[n] = n / 2 == i - 8'h4E || m / 2 == i - 8'h4E;
         else if (i == 8'h53) o_mask[n] = n >= 10 && n <= 13;
         else if (i == 8'h54) o_mask[n] = n >= 11 && n <= 12;
         else if (i >= 8'h55 && i <= 8'h57)
            o_mask[n] = n / 3 == i - 8'h55 || m / 3 == i - 8'h55;
         else if (i == 8'h58) o_mask[n] = n >= 9 && n <= 14;
         else if (i == 8'h59) o_mask[n] = n >= 10 && n <= 13;
         else if (i == 8'h5A) o_mask[n] = n >= 11 && n <= 12;
         else if (i >= 8'h5B && i <= 8'h5C)
            o_mask[n] = n / 4 == i - 8'h5B || m / 4 == i - 8'h5B;
         else if (i == 8'h5D) o_mask[n] = n >= 8 && n <= 15;
         else if (i == 8'h5E) o_mask[n] = n >= 10 && n <= 13;
         else if (i == 8'h5F) o_mask[n] = n >= 11 && n <= 12;
         else if (i >= 8'h60 && i <= 8'h77) o_mask[n] = n <= i - 8'h60;
         else if (i >= 8'h78 && i <= 8'h8F) o_mask[n] = m <= i - 8'h78;
         // reserved indices leave every channel off
         else o_mask[n] = 1'b0;
      end
   end
endmodule : lbc_chase_decode

// ==== rtl/lbc_top.sv ====
// Purpose: group blink period generator and chase gating of 24 open-drain channels
// Assumes: Avalon-MM slave, word addressed; output gate pin is asynchronous
// Notes:   individual duty waveforms arrive from logic on the same clock
`timescale 1ns/1ns
module lbc_top (
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   input  wire logic [5:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_out_gate_n,
   input  wire logic [23:0] i_indiv_pwm,
   output logic      [23:0] o_led_out,
   output logic      [23:0] o_led_oe_n
);
   // bus registers
   logic [7:0]  second_mode_register;
   logic [7:0]  group_duty_register;
   logic [7:0]  group_blink_period;
   logic [7:0]  chase_pattern_index;
   logic [7:0]  output_state_register [lbc_pkg::NUM_STATE_REGS];
   logic        chase_active;

   // gate pin synchroniser
   logic        gate_meta;
   logic        gate_sync;

   // group waveform
   logic        blink_slice;
   logic        dim_slice;
   logic [7:0]  slice_count;
   logic [7:0]  phase;
   logic        group_on;

   logic        accept;
   logic        wr_go;
   logic        group_blink_select;
   logic [23:0] chase_mask;
   logic [23:0] gate_mask;
   logic [23:0] state_on;
   logic [31:0] next_readdata;
   logic [5:0]  state_sel;

   assign group_blink_select = second_mode_register[lbc_pkg::MODE_BLINK_BIT];
   assign state_sel          = i_avs_address - lbc_pkg::IDX_STATE_FIRST;

   // one wait state: request seen with waitrequest high, answered the next cycle
   assign accept = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
   assign wr_go  = accept && i_avs_write && i_avs_byteenable[0];

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_avs_waitrequest <= 1'b1;
      end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
         o_avs_waitrequest <= 1'b0;
      end else begin
         o_avs_waitrequest <= 1'b1;
      end
   end

   always_comb begin
      next_readdata = 32'h00000000;
      if (i_avs_address == lbc_pkg::IDX_SECOND_MODE) begin
         next_readdata[7:0] = (second_mode_register & 8'h28) | lbc_pkg::MODE_FIXED_ONES;
      end else if (i_avs_address == lbc_pkg::IDX_GROUP_DUTY) begin
         next_readdata[7:0] = group_duty_register;
      end else if (i_avs_address == lbc_pkg::IDX_GROUP_PERIOD) begin
         next_readdata[7:0] = group_blink_period;
      end else if (i_avs_address == lbc_pkg::IDX_CHASE_INDEX) begin
         next_readdata[7:0] = chase_pattern_index;
      end else if (i_avs_address >= lbc_pkg::IDX_STATE_FIRST &&
                   i_avs_address <= lbc_pkg::IDX_STATE_LAST) begin
         next_readdata[7:0] = output_state_register[state_sel[2:0]];
      end else if (i_avs_address == lbc_pkg::IDX_STATUS) begin
         next_readdata[2:0] = {chase_active, gate_sync, group_on};
      end
   end

   // read data captured while waitrequest is high, stands at the answer edge
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_avs_readdata <= 32'h00000000;
      end else if (i_avs_read && o_avs_waitrequest) begin
         o_avs_readdata <= next_readdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         second_mode_register <= 8'h00;
         group_duty_register  <= lbc_pkg::RST_GROUP_DUTY;
      end else if (wr_go && i_avs_address == lbc_pkg::IDX_SECOND_MODE) begin
         // only the blink select and output-change bits are writable
         second_mode_register <= i_avs_writedata[7:0] & 8'h28;
      end else if (wr_go && i_avs_address == lbc_pkg::IDX_GROUP_DUTY) begin
         group_duty_register <= i_avs_writedata[7:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         group_blink_period <= lbc_pkg::RST_GROUP_PERIOD;
      end else if (wr_go && i_avs_address == lbc_pkg::IDX_GROUP_PERIOD) begin
         group_blink_period <= i_avs_writedata[7:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         chase_pattern_index <= lbc_pkg::RST_CHASE_INDEX;
         chase_active        <= 1'b0;
      end else if (wr_go && i_avs_address == lbc_pkg::IDX_CHASE_INDEX) begin
         chase_pattern_index <= i_avs_writedata[7:0];
         chase_active        <= i_avs_writedata[7:0] != lbc_pkg::CHASE_EXIT;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         for (int r = 0; r < lbc_pkg::NUM_STATE_REGS; r++) begin
            output_state_register[r] <= lbc_pkg::RST_STATE;
         end
      end else if (wr_go && i_avs_address >= lbc_pkg::IDX_STATE_FIRST &&
                   i_avs_address <= lbc_pkg::IDX_STATE_LAST) begin
         output_state_register[state_sel[2:0]] <= i_avs_writedata[7:0];
      end
   end

   // gate pin passes two flops before use
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         gate_meta <= 1'b1;
         gate_sync <= 1'b1;
      end else begin
         gate_meta <= i_out_gate_n;
         gate_sync <= gate_meta;
      end
   end

   lbc_tick_div #(
      .CYCLES (lbc_pkg::BLINK_SLICE_CYC)
   ) u_blink_div (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .o_tick    (blink_slice)
   );

   lbc_tick_div #(
      .CYCLES (lbc_pkg::DIM_SLICE_CYC)
   ) u_dim_div (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .o_tick    (dim_slice)
   );

   // blink mode: period code plus one blink slices per duty step; dim mode: one dim slice per step
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         slice_count <= 8'h00;
         phase       <= 8'h00;
      end else if (!group_blink_select) begin
         slice_count <= 8'h00;
         if (dim_slice) begin
            phase <= phase + 8'h01;
         end
      end else if (blink_slice) begin
         if (slice_count >= group_blink_period) begin
            slice_count <= 8'h00;
            phase       <= phase + 8'h01;
         end else begin
            slice_count <= slice_count + 8'h01;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         group_on <= 1'b0;
      end else begin
         group_on <= phase < group_duty_register;
      end
   end

   always_comb begin
      logic [1:0] code;
      code     = 2'h0;
      state_on = 24'h000000;
      for (int n = 0; n < lbc_pkg::NUM_CH; n++) begin
         code = output_state_register[n / 4][(n % 4) * 2 +: 2];
         unique case (code)
            lbc_pkg::ST_OFF:   state_on[n] = 1'b0;
            lbc_pkg::ST_ON:    state_on[n] = 1'b1;
            lbc_pkg::ST_INDIV: state_on[n] = i_indiv_pwm[n];
            lbc_pkg::ST_GROUP: state_on[n] = i_indiv_pwm[n] && group_on;
         endcase
      end
   end

   lbc_chase_decode u_chase_decode (
      .i_index (chase_pattern_index),
      .o_mask  (chase_mask)
   );

   // outside chase operation every channel follows its state
   assign gate_mask = chase_active ? chase_mask : 24'hFFFFFF;

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_led_oe_n <= 24'hFFFFFF;
      end else if (gate_sync) begin
         o_led_oe_n <= 24'hFFFFFF;
      end else begin
         o_led_oe_n <= ~(gate_mask & state_on);
      end
   end

   // open-drain outputs only ever pull low
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_led_out <= 24'h000000;
      end else begin
         o_led_out <= 24'h000000;
      end
   end
endmodule : lbc_top

// ==== test/lbc_assertions.sv ====
// Purpose: port-level checks on the blink and chase block
// Assumes: one clock domain, reset synchronous active high
// Notes:   chase checks only bound channels that must be dark
`timescale 1ns/1ns
module lbc_checker (
   input wire logic        i_clock,
   input wire logic        i_sys_rst,
   input wire logic [5:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_out_gate_n,
   input wire logic [23:0] i_indiv_pwm,
   input wire logic [23:0] o_led_out,
   input wire logic [23:0] o_led_oe_n
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   wire acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
              && i_avs_address == lbc_pkg::IDX_CHASE_INDEX;
   wire [7:0] wd = i_avs_writedata[7:0];

   a_wait_release: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low two cycles");
   a_req_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("request not answered");
   a_upper_zero: assert property (o_avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
      && i_avs_address == 6'h3F |-> o_avs_readdata == 32'h0) else $error("unmapped read");
   a_gate_off: assert property (i_out_gate_n [*4] |=> &o_led_oe_n)
      else $error("gate high but channel driven");
   a_drain_zero: assert property (o_led_out == 24'h0)
      else $error("output data not zero");
   a_none_off: assert property (acc && wd == 8'h01 |-> ##2 &o_led_oe_n)
      else $error("pattern none lit a channel");
   a_reserved_off: assert property (acc && wd inside {[8'h90:8'hFE]} |-> ##2 &o_led_oe_n)
      else $error("reserved pattern lit a channel");
   a_single_only: assert property (acc && wd inside {[8'h07:8'h1E]} |-> ##2
      (~o_led_oe_n & ~(24'h1 << ($past(wd, 2) - 8'h07))) == 24'h0)
      else $error("sweep lit a wrong channel");

   c_chase_write: cover property (acc);
   c_gate_high: cover property (i_out_gate_n [*4]);
   c_back_to_back: cover property (!o_avs_waitrequest ##2 !o_avs_waitrequest);
endmodule : lbc_checker

bind lbc_top lbc_checker chk_i (.i_clock, .i_sys_rst, .i_avs_address, .i_avs_read,
   .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
   .o_avs_waitrequest, .i_out_gate_n, .i_indiv_pwm, .o_led_out, .o_led_oe_n);

// ==== test/lbc_bus_master.sv ====
// Purpose: register bus controller on the far side of the block
// Assumes: slave answers by dropping waitrequest for one cycle
// Notes:   one request at a time; bounded wait reports a timeout
`timescale 1ns/1ns
module lbc_bus_master (
   input  wire logic        i_clock,
   input  wire logic        i_waitrequest,
   input  wire logic [31:0] i_readdata,
   output logic      [5:0]  o_address,
   output logic             o_read,
   output logic             o_write,
   output logic      [31:0] o_writedata,
   output logic      [3:0]  o_byteenable
);
   initial begin
      o_address = 6'h0;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0;
      o_byteenable = 4'h0;
   end
   // starts on a fresh edge so release and the next raise never share a time step
   task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [23:0] q, output bit to);
      int n;
      n = 0;
      @(posedge i_clock);
      o_address <= a;
      o_read <= !wr;
      o_write <= wr;
      o_writedata <= {24'h0, d};
      o_byteenable <= be;
      // sample at the rising edge; the answer and read data stand at that edge
      do begin
         @(posedge i_clock);
         n++;
      end while (i_waitrequest !== 1'b0 && n < 50);
      q = i_readdata[23:0];
      to = (n >= 50);
      o_read <= 1'b0;
      o_write <= 1'b0;
   endtask : xfer
endmodule : lbc_bus_master

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for chase gating and blink registers
// Assumes: 10 MHz clock, gate pin toggled by an unrelated 800 ns clock
// Notes:   full blink periods exceed the run length and are not timed
`timescale 1ns/1ns
module tb_top;
   logic        i_clock, i_sys_rst, i_out_gate_n, link_en, g_q, rd_req, wr_req;
   logic [23:0] i_indiv_pwm, on, q, oe, drn;
   logic [31:0] rdat, wdat;
   logic [5:0]  adr;
   logic [3:0]  be;
   logic        wreq;
   int          n_errors, comparisons, g_cnt;

   lbc_bus_master m (.i_clock(i_clock), .i_waitrequest(wreq), .i_readdata(rdat),
      .o_address(adr), .o_read(rd_req), .o_write(wr_req), .o_writedata(wdat),
      .o_byteenable(be));
   lbc_top dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_avs_address(adr),
      .i_avs_read(rd_req), .i_avs_write(wr_req), .i_avs_writedata(wdat),
      .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
      .i_out_gate_n(i_out_gate_n), .i_indiv_pwm(i_indiv_pwm), .o_led_out(drn),
      .o_led_oe_n(oe));

   initial i_clock = 1'b0;
   always #50 i_clock = ~i_clock;
   // counts samples the gate has held its level, so checks skip the synchroniser delay
   always @(posedge i_clock) begin
      g_q <= i_out_gate_n;
      g_cnt <= (i_out_gate_n === g_q) ? g_cnt + 1 : 0;
   end
   initial begin
      i_out_gate_n = 1'b0;
      wait (link_en);
      #37;
      while (link_en) #400 i_out_gate_n = ~i_out_gate_n;
      i_out_gate_n = 1'b0;
   end

   function automatic logic [23:0] mir(input logic [23:0] v);
      logic [23:0] r;
      r = {<<{v}};
      return v | r;
   endfunction : mir
   function automatic logic [23:0] exp_mask(input logic [7:0] x);
      case (x) inside
         8'h00: return 24'hFFFFFF;
         8'h02: return 24'hAAAAAA;
         8'h03: return 24'h555555;
         8'h04: return 24'h924924;
         8'h05: return 24'h492492;
         8'h06: return 24'h249249;
         [8'h07:8'h1E]: return 24'h1 << (x - 8'h07);
         [8'h1F:8'h2A]: return 24'h3 << 2 * (x - 8'h1F);
         [8'h2B:8'h32]: return 24'h7 << 3 * (x - 8'h2B);
         [8'h33:8'h38]: return 24'hF << 4 * (x - 8'h33);
         [8'h39:8'h3D]: return 24'h1F << 5 * (x - 8'h39);
         [8'h3E:8'h41]: return 24'h3F << 6 * (x - 8'h3E);
         [8'h42:8'h4D]: return mir(24'h1 << (x - 8'h42));
         [8'h4E:8'h52]: return mir(24'h3 << 2 * (x - 8'h4E));
         [8'h55:8'h57]: return mir(24'h7 << 3 * (x - 8'h55));
         8'h53, 8'h59, 8'h5E: return 24'h003C00;
         8'h54, 8'h5A, 8'h5F: return 24'h001800;
         8'h58: return 24'h007E00;
         8'h5B: return 24'hF0000F;
         8'h5C: return 24'h0F00F0;
         8'h5D: return 24'h00FF00;
         [8'h60:8'h77]: return (24'h2 << (x - 8'h60)) - 24'h1;
         [8'h78:8'h8F]: return ~((24'h1 << (23 - (x - 8'h78))) - 24'h1);
         default: return 24'h0;
      endcase
   endfunction : exp_mask

   task automatic end_sim();
      if (n_errors == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                      input logic [3:0] b);
      bit to;
      m.xfer(wr, a, d, b, q, to);
      if (to) begin
         n_errors++;
         $display("Error at %0t: bus timeout", $time);
         end_sim();
      end
   endtask : bus
   task automatic st_wr(input logic [7:0] v, input int r);
      bus(1'b1, lbc_pkg::IDX_STATE_FIRST + 6'(r), v, 4'h1);
      for (int k = 0; k < 4; k++) on[4 * r + k] = v[2 * k];
   endtask : st_wr
   // pm marks channels that follow the individual duty input alone
   task automatic oe_chk(input logic [23:0] exp, input logic [23:0] pm);
      logic [23:0] pw;
      pw = 24'($urandom);
      i_indiv_pwm <= pw;
      @(posedge i_clock);
      @(negedge i_clock);
      chk(oe, ~(exp | (pm & pw)));
   endtask : oe_chk

   initial begin
      logic [7:0] x;
      int s;
      n_errors = 0;
      comparisons = 0;
      link_en = 1'b0;
      i_sys_rst = 1'b1;
      i_indiv_pwm = 24'h0;
      on = 24'h0;
      s = $urandom(32'h800fd85c);
      repeat (5) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      bus(1'b0, lbc_pkg::IDX_GROUP_DUTY, 8'h0, 4'h1);
      chk(q, 24'hFF);
      bus(1'b0, 6'h3F, 8'h0, 4'h1);
      chk(q, 24'h0);
      x = 8'($urandom);
      bus(1'b1, lbc_pkg::IDX_GROUP_PERIOD, x, 4'h1);
      bus(1'b0, lbc_pkg::IDX_GROUP_PERIOD, 8'h0, 4'h1);
      chk(q, {16'h0, x});
      bus(1'b1, lbc_pkg::IDX_CHASE_INDEX, 8'h07, 4'hE);
      bus(1'b0, lbc_pkg::IDX_CHASE_INDEX, 8'h0, 4'h1);
      chk(q, 24'h0);
      for (int r = 0; r < 6; r++) st_wr(8'h55, r);
      for (int i = 0; i < 255; i++) begin
         bus(1'b1, lbc_pkg::IDX_CHASE_INDEX, 8'(i), 4'h1);
         oe_chk(exp_mask(8'(i)), 24'h0);
      end
      repeat (20) begin
         for (int r = 0; r < 6; r++) st_wr(8'($urandom) & 8'h55, r);
         x = 8'($urandom % 255);
         bus(1'b1, lbc_pkg::IDX_CHASE_INDEX, x, 4'h1);
         oe_chk(exp_mask(x) & on, 24'h0);
      end
      bus(1'b0, lbc_pkg::IDX_STATUS, 8'h0, 4'h1);
      chk(q & 24'h4, 24'h4);
      bus(1'b1, lbc_pkg::IDX_CHASE_INDEX, 8'hFF, 4'h1);
      oe_chk(on, 24'h0);
      bus(1'b0, lbc_pkg::IDX_STATUS, 8'h0, 4'h1);
      chk(q & 24'h4, 24'h0);
      // group duty zero keeps the group waveform off in both modes
      bus(1'b1, lbc_pkg::IDX_GROUP_DUTY, 8'h00, 4'h1);
      for (int b = 0; b < 2; b++) begin
         bus(1'b1, lbc_pkg::IDX_SECOND_MODE, 8'(b << 5), 4'h1);
         for (int r = 0; r < 6; r++) st_wr(r == 0 ? 8'hEE : 8'h00, r);
         oe_chk(24'h0, 24'h5);
      end
      // blink select stored, fixed bits read as one
      bus(1'b0, lbc_pkg::IDX_SECOND_MODE, 8'h0, 4'h1);
      chk(q, 24'h25);
      for (int r = 0; r < 6; r++) st_wr(8'h55, r);
      bus(1'b1, lbc_pkg::IDX_CHASE_INDEX, 8'h00, 4'h1);
      link_en = 1'b1;
      repeat (120) begin
         @(negedge i_clock);
         if (g_cnt >= 3) chk(oe, g_q ? 24'hFFFFFF : 24'h0);
      end
      link_en = 1'b0;
      repeat (12) @(posedge i_clock);
      bus(1'b1, lbc_pkg::IDX_CHASE_INDEX, 8'h5B, 4'h1);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      bus(1'b0, lbc_pkg::IDX_CHASE_INDEX, 8'h0, 4'h1);
      chk(q, 24'h0);
      end_sim();
   end
endmodule : tb_top
